//--- include/rate_gen_pkg.sv
// constants shared by the baud-rate generator files
package rate_gen_pkg;
    localparam int DIV_WIDTH = 12;
    localparam int ADDR_WIDTH = 2;
    // register word indices (byte address = 4 * index)
    localparam logic [ADDR_WIDTH-1:0] REG_DIV_LOW = 2'h0;
    localparam logic [ADDR_WIDTH-1:0] REG_DIV_HIGH = 2'h1;
    localparam logic [ADDR_WIDTH-1:0] REG_CONTROL = 2'h2;
    localparam logic [ADDR_WIDTH-1:0] REG_STATUS = 2'h3;
    // field positions
    localparam int HIGH_FIELD_MSB = 3;
    localparam int CTRL_SYNC_MODE_BIT = 0;
    localparam int CTRL_DOUBLE_SPEED_BIT = 1;
    localparam int CTRL_POLARITY_BIT = 2;
    localparam int STAT_TICK_BIT = 0;
    localparam int STAT_LEVEL_BIT = 1;
    localparam int STAT_XCK_BIT = 2;
    // reset values
    localparam logic [7:0] DIV_LOW_RESET = 8'h00;
    localparam logic [3:0] DIV_HIGH_RESET = 4'h0;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    // oversampling factors
    localparam logic [4:0] OVERSAMPLE_NORMAL = 5'h10;
    localparam logic [4:0] OVERSAMPLE_DOUBLE = 5'h08;
    // fixed bus answer latency in cycles
    localparam int BUS_LATENCY = 1;
endpackage

//--- include/rate_if.sv
// carrier between register file and prescaler
`timescale 1ns/100ps
interface rate_if;
    logic [rate_gen_pkg::DIV_WIDTH-1:0] divisor;
    logic reload;
    logic double_speed;
    logic sync_mode;
    logic tick;
    logic bit_tick;
    modport ctrl (output divisor, output reload, output double_speed, output sync_mode,
        input tick, input bit_tick);
    modport gen (input divisor, input reload, input double_speed, input sync_mode,
        output tick, output bit_tick);
endinterface

//--- design/rate_prescaler.sv
// down-counting prescaler with oversampling stage
`timescale 1ns/100ps
module rate_prescaler
    import rate_gen_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // rate control
    rate_if.gen rif
);
    logic [DIV_WIDTH-1:0] count_reg;
    logic [4:0] phase_reg;
    logic tick_reg;
    logic bit_reg;
    wire count_done = (count_reg == '0);
    wire [4:0] over_last = (rif.double_speed && !rif.sync_mode) ?
        (OVERSAMPLE_DOUBLE - 5'h01) : (OVERSAMPLE_NORMAL - 5'h01);
    wire phase_done = (phase_reg >= over_last);

    // a reload restarts both stages so the new rate begins at once
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
            phase_reg <= '0;
            tick_reg <= 1'b0;
            bit_reg <= 1'b0;
        end else if (rif.reload) begin
            count_reg <= rif.divisor;
            phase_reg <= '0;
            tick_reg <= 1'b0;
            bit_reg <= 1'b0;
        end else begin
            count_reg <= count_done ? rif.divisor : count_reg - 1'b1;
            tick_reg <= count_done;
            bit_reg <= count_done && phase_done;
            if (count_done) begin
                phase_reg <= phase_done ? 5'h00 : phase_reg + 5'h01;
            end
        end
    end
    assign rif.tick = tick_reg;
    assign rif.bit_tick = bit_reg;

    // bit period is oversample * (divisor + 1) clocks
    property p_bit_period;
        @(posedge clock) disable iff (!resetn)
        (bit_reg && !rif.reload) ##1 (!rif.reload)[*7] |-> !bit_reg;
    endproperty
    a_bit_period_gap: assert property (p_bit_period)
        else $error("bit ticks closer than eight clocks");
    a_reload_restart: assert property (@(posedge clock) disable iff (!resetn)
        rif.reload |=> (count_reg == $past(rif.divisor)) && (phase_reg == 5'h00))
        else $error("prescaler not reloaded by low divisor write");
    a_double_phase: assert property (@(posedge clock) disable iff (!resetn)
        (rif.double_speed && !rif.sync_mode && !rif.reload && phase_reg < 5'h08)
            |=> phase_reg < 5'h08)
        else $error("double speed phase beyond eight");
endmodule

//--- design/baud_rate_generator.sv
// avalon register file, prescaler and synchronous clock edge logic
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - polarity 0 drives on rising, samples on falling clock edge; 1 swaps.
// - divisor is 12 bits; high register holds top four, low holds bottom eight.
// - high register upper nibble reads zero; software writes it zero.
// - writing the low divisor byte reloads the prescaler immediately.
// - double speed halves fixed divisor from 16 to 8, asynchronous only.
module baud_rate_generator
    import rate_gen_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [rate_gen_pkg::ADDR_WIDTH-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // serial pins
    input wire logic sync_clock_pin,
    input wire logic receive_pin,
    input wire logic tx_data_in,
    output logic transmit_pin,
    output logic rx_data_out,
    output logic rx_sample_strobe,
    output logic tx_change_strobe,
    output logic bit_rate_tick
);
    import rate_gen_pkg::*;

    rate_if rif ();

    logic [7:0] div_low_reg;
    logic [3:0] div_high_reg;
    logic [2:0] control_reg;
    logic ack_reg;
    logic waitrequest_reg;
    logic [31:0] readdata_reg;
    logic [2:0] xck_sync_reg;
    logic [1:0] rxd_sync_reg;
    logic transmit_reg;
    logic rx_data_reg;
    logic rx_strobe_reg;
    logic tx_strobe_reg;
    logic bit_tick_reg;
    logic tick_seen_reg;

    // register decode; the answer comes one cycle after the request
    wire request = (read || write) && !ack_reg;
    wire write_hit = write && !ack_reg && byteenable[0];
    wire wr_low = write_hit && (address == REG_DIV_LOW);
    wire wr_high = write_hit && (address == REG_DIV_HIGH);
    wire wr_ctrl = write_hit && (address == REG_CONTROL);
    wire polarity = control_reg[CTRL_POLARITY_BIT] && control_reg[CTRL_SYNC_MODE_BIT];

    function automatic logic [31:0] read_mux(input logic [ADDR_WIDTH-1:0] a);
        read_mux = 32'h0000_0000;
        case (a)
            REG_DIV_LOW: read_mux[7:0] = div_low_reg;
            REG_DIV_HIGH: read_mux[HIGH_FIELD_MSB:0] = div_high_reg;
            REG_CONTROL: read_mux[2:0] = control_reg;
            REG_STATUS: begin
                read_mux[STAT_TICK_BIT] = tick_seen_reg;
                read_mux[STAT_LEVEL_BIT] = transmit_reg;
                read_mux[STAT_XCK_BIT] = xck_sync_reg[1];
            end
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    // edge detect on the synchronised clock pin; stage 0 feeds stage 1 only
    wire xck_rise = xck_sync_reg[1] && !xck_sync_reg[2];
    wire xck_fall = !xck_sync_reg[1] && xck_sync_reg[2];
    wire change_edge = polarity ? xck_fall : xck_rise;
    wire sample_edge = polarity ? xck_rise : xck_fall;
    wire sync_on = control_reg[CTRL_SYNC_MODE_BIT];

    // a low byte write reloads with the byte on the bus, not the stale register
    wire [DIV_WIDTH-1:0] divisor_stored = {div_high_reg, div_low_reg};
    wire [DIV_WIDTH-1:0] divisor_loaded = {div_high_reg, writedata[7:0]};
    assign rif.divisor = wr_low ? divisor_loaded : divisor_stored;
    assign rif.reload = wr_low;
    assign rif.double_speed = control_reg[CTRL_DOUBLE_SPEED_BIT];
    assign rif.sync_mode = sync_on;

    rate_prescaler u_prescaler (
        .clock(clock),
        .resetn(resetn),
        .rif(rif)
    );

    // divisor and control registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_low_reg <= DIV_LOW_RESET;
            div_high_reg <= DIV_HIGH_RESET;
            control_reg <= CONTROL_RESET;
        end else begin
            if (wr_low) div_low_reg <= writedata[7:0];
            if (wr_high) div_high_reg <= writedata[HIGH_FIELD_MSB:0];
            if (wr_ctrl) control_reg <= writedata[2:0];
        end
    end

    // bus handshake: waitrequest high until the answer cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= request;
            waitrequest_reg <= !request;
            readdata_reg <= (read && !ack_reg) ? read_mux(address) : readdata_reg;
        end
    end
    assign readdata = readdata_reg;
    assign waitrequest = waitrequest_reg;

    // sticky tick flag: a new tick wins over a status read clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_seen_reg <= 1'b0;
        end else if (rif.bit_tick) begin
            tick_seen_reg <= 1'b1;
        end else if (read && !ack_reg && address == REG_STATUS) begin
            tick_seen_reg <= 1'b0;
        end
    end

    // pin synchronisers; pins come from outside the clock domain
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            xck_sync_reg <= 3'h0;
            rxd_sync_reg <= 2'h3;
        end else begin
            xck_sync_reg <= {xck_sync_reg[1:0], sync_clock_pin};
            rxd_sync_reg <= {rxd_sync_reg[0], receive_pin};
        end
    end

    // launch and capture; async mode uses the prescaler bit tick for both
    wire launch = sync_on ? change_edge : rif.bit_tick;
    wire capture = sync_on ? sample_edge : rif.bit_tick;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            transmit_reg <= 1'b1;
            rx_data_reg <= 1'b1;
            rx_strobe_reg <= 1'b0;
            tx_strobe_reg <= 1'b0;
            bit_tick_reg <= 1'b0;
        end else begin
            if (launch) transmit_reg <= tx_data_in;
            if (capture) rx_data_reg <= rxd_sync_reg[1];
            rx_strobe_reg <= capture;
            tx_strobe_reg <= launch;
            bit_tick_reg <= rif.bit_tick;
        end
    end
    assign transmit_pin = transmit_reg;
    assign rx_data_out = rx_data_reg;
    assign rx_sample_strobe = rx_strobe_reg;
    assign tx_change_strobe = tx_strobe_reg;
    assign bit_rate_tick = bit_tick_reg;

    sequence s_rise_seen;
        xck_sync_reg[1] && !xck_sync_reg[2];
    endsequence
    sequence s_fall_seen;
        !xck_sync_reg[1] && xck_sync_reg[2];
    endsequence
    a_pol0_tx_rise: assert property (@(posedge clock) disable iff (!resetn)
        (sync_on && !polarity) ##0 s_rise_seen |=> tx_strobe_reg)
        else $error("polarity 0 did not launch on rising edge");
    a_pol0_rx_fall: assert property (@(posedge clock) disable iff (!resetn)
        (sync_on && !polarity) ##0 s_fall_seen |=> rx_strobe_reg && !tx_strobe_reg)
        else $error("polarity 0 did not sample on falling edge");
    a_pol1_swap: assert property (@(posedge clock) disable iff (!resetn)
        (sync_on && polarity) ##0 s_rise_seen |=> rx_strobe_reg && !tx_strobe_reg)
        else $error("polarity 1 did not sample on rising edge");
    a_high_nibble_zero: assert property (@(posedge clock) disable iff (!resetn)
        (ack_reg && $past(read) && $past(address) == REG_DIV_HIGH) |-> readdata[31:4] == 28'h0)
        else $error("reserved divisor bits not zero");
    a_divisor_join: assert property (@(posedge clock) disable iff (!resetn)
        wr_high |=> rif.divisor[11:8] == $past(writedata[3:0]))
        else $error("high divisor bits not stored");
    a_bus_answer: assert property (@(posedge clock) disable iff (!resetn)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_one_answer: assert property (@(posedge clock) disable iff (!resetn)
        ack_reg |=> !ack_reg)
        else $error("bus answer stood longer than one cycle");

    // pulse, flag, divisor and read data checks; the tick flag must survive a clear in the same cycle
    a_pol1_tx_fall: assert property (@(posedge clock) disable iff (!resetn)
        (sync_on && polarity) ##0 s_fall_seen |=> tx_strobe_reg && !rx_strobe_reg)
        else $error("polarity 1 did not launch on falling edge");
    a_async_tick_only: assert property (@(posedge clock) disable iff (!resetn)
        (!sync_on && !rif.bit_tick) |=> !tx_strobe_reg && !rx_strobe_reg)
        else $error("async strobe without bit tick");
    a_tick_set_wins: assert property (@(posedge clock) disable iff (!resetn)
        rif.bit_tick |=> tick_seen_reg)
        else $error("bit tick flag not set");
    a_tick_read_clear: assert property (@(posedge clock) disable iff (!resetn)
        (read && !ack_reg && address == REG_STATUS && !rif.bit_tick) |=> !tick_seen_reg)
        else $error("bit tick flag not cleared by status read");
    a_low_byte_store: assert property (@(posedge clock) disable iff (!resetn)
        wr_low |=> div_low_reg == $past(writedata[7:0]))
        else $error("low divisor byte not stored");
    a_reload_new_low: assert property (@(posedge clock) disable iff (!resetn)
        wr_low |-> rif.divisor[7:0] == writedata[7:0])
        else $error("reload does not carry the written low byte");
    a_read_data_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(read && !ack_reg) |=> $stable(readdata_reg))
        else $error("read data changed without a read");
endmodule

//--- sim/remote_serial_peer.sv
// remote serial device model driving the synchronous clock and receive pins
`timescale 1ns/100ps
module remote_serial_peer (
    // timing reference
    input wire logic clock,
    // serial pins
    input wire logic transmit_pin,
    output logic sync_clock_pin,
    output logic receive_pin
);
    // clock pin stands still outside frames, receive line idles high
    initial begin
        sync_clock_pin = 1'b0;
        receive_pin = 1'b1;
    end
    // data is set up well before the edge so the 2-flop synchroniser never sees both move
    task automatic pin_edge(input logic level, input logic rx_bit);
        @(posedge clock);
        receive_pin <= rx_bit;
        repeat (4) @(posedge clock);
        sync_clock_pin <= level;
        repeat (8) @(posedge clock);
    endtask
endmodule

//--- sim/baud_rate_generator_tb.sv
// self-checking bench for the baud-rate generator
`timescale 1ns/100ps
module baud_rate_generator_tb;
    import rate_gen_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_WIDTH-1:0] address = '0;
    logic read = 1'b0, write = 1'b0, tx_data_in = 1'b0;
    logic [31:0] writedata = '0, readdata, rd, rnd = 32'h85e08331;
    logic [3:0] byteenable = 4'hf;
    logic waitrequest, sync_clock_pin, receive_pin, transmit_pin, rx_data_out, bit_rate_tick;
    logic v, a, b, rs, ts;
    int fails = 0, n_compared = 0, cycles = 0, n, d, n_rs = 0, n_ts = 0, rs0, ts0;
    baud_rate_generator i_dut (.clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .sync_clock_pin(sync_clock_pin),
        .receive_pin(receive_pin), .tx_data_in(tx_data_in), .transmit_pin(transmit_pin),
        .rx_data_out(rx_data_out), .rx_sample_strobe(rs), .tx_change_strobe(ts),
        .bit_rate_tick(bit_rate_tick));
    remote_serial_peer i_peer (.clock(clock), .transmit_pin(transmit_pin),
        .sync_clock_pin(sync_clock_pin), .receive_pin(receive_pin));
    always #5 clock = ~clock;
    // galois shift register, fixed seed keeps runs repeatable
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one avalon transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_WIDTH-1:0] adr,
        input logic [31:0] wd, input logic [3:0] be);
        @(posedge clock);
        address <= adr;
        writedata <= wd;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // cycles until the next bit tick, bounded
    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(posedge clock);
            cnt++;
        end while (bit_rate_tick !== 1'b1 && cnt < 400);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // run-away guard well above the expected length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 50000) begin
            fails++;
            give_verdict();
        end
    end
    // strobe pulses counted for the per-edge checks
    always @(posedge clock) begin
        if (rs === 1'b1) n_rs++;
        if (ts === 1'b1) n_ts++;
    end
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        // reset values of the register file
        bus(1'b0, REG_DIV_LOW, 32'h0, 4'hf);
        check("div_low reset", rd, {24'h0, DIV_LOW_RESET});
        bus(1'b0, REG_DIV_HIGH, 32'h0, 4'hf);
        check("div_high reset", rd, {28'h0, DIV_HIGH_RESET});
        bus(1'b0, REG_CONTROL, 32'h0, 4'hf);
        check("control reset", rd, {29'h0, CONTROL_RESET});
        // reserved upper nibble written with ones reads back zero
        rnd = lfsr_next(rnd);
        bus(1'b1, REG_DIV_HIGH, {24'h0, 4'hf, rnd[3:0]}, 4'hf);
        bus(1'b0, REG_DIV_HIGH, 32'h0, 4'hf);
        check("div_high field", rd, {28'h0, rnd[3:0]});
        bus(1'b1, REG_DIV_LOW, 32'h5a, 4'h0);
        bus(1'b0, REG_DIV_LOW, 32'h0, 4'hf);
        check("div_low lane off", rd, 32'h0);
        // async rates: start from the largest divisor so only a reload gives an early tick
        for (int ds = 0; ds < 2; ds++) begin
            rnd = lfsr_next(rnd);
            d = rnd[2:0];
            bus(1'b1, REG_CONTROL, {30'h0, ds[0], 1'b0}, 4'hf);
            bus(1'b1, REG_DIV_HIGH, 32'h0f, 4'hf);
            bus(1'b1, REG_DIV_LOW, 32'hff, 4'hf);
            bus(1'b1, REG_DIV_HIGH, 32'h00, 4'hf);
            bus(1'b1, REG_DIV_LOW, d, 4'hf);
            wait_tick(n);
            check("reload early tick", n <= (ds ? 8 : 16) * (d + 1) + 4, 1);
            wait_tick(n);
            check("bit period", n, (ds ? 8 : 16) * (d + 1));
        end
        // status: tick flag set, line launched low from tx_data_in, clock pin low
        bus(1'b0, REG_STATUS, 32'h0, 4'hf);
        check("status", rd, 32'h1 << STAT_TICK_BIT);
        // synchronous mode, divisor left alone while frames run
        for (int pol = 0; pol < 2; pol++) begin
            rnd = lfsr_next(rnd);
            {v, a, b} = rnd[2:0];
            bus(1'b1, REG_CONTROL, {29'h0, pol[0], 2'b01}, 4'hf);
            // one edge so a strobe from the last async tick is already counted
            @(posedge clock);
            rs0 = n_rs;
            ts0 = n_ts;
            tx_data_in <= v;
            i_peer.pin_edge(1'b1, a);
            if (pol == 0)
                check("tx after rise", transmit_pin, v);
            check("launch count rise", n_ts - ts0, pol ? 0 : 1);
            check("sample count rise", n_rs - rs0, pol ? 1 : 0);
            tx_data_in <= ~v;
            i_peer.pin_edge(1'b0, b);
            check("tx after fall", transmit_pin, pol ? {~v} : {v});
            check("rx sampled", rx_data_out, pol ? a : b);
            check("launch count", n_ts - ts0, 1);
            check("sample count", n_rs - rs0, 1);
        end
        give_verdict();
    end
endmodule
